// ---- shared/xpt_pkg.sv ----
package xpt_pkg;

    // matrix size
    localparam int N_OUT = 16;
    localparam int N_IN = 32;
    localparam int SEL_W = 5;
    localparam int OADDR_W = 4;

    // serial-mode frame: one six-bit slot per output, bit 0 first in
    localparam int SLOT_W = 6;
    localparam int FRAME_BITS = 96;

    // addressed-mode word: bit 0 first in
    localparam int WORD_BITS = 10;
    localparam int WORD_OADDR_LSB = 0;
    localparam int WORD_SEL_LSB = 4;
    localparam int WORD_OFF_BIT = 9;

    // route values forced by the level pins
    localparam logic [SEL_W-1:0] SEL_INPUT0 = 5'h00;
    localparam logic OFF_HIZ = 1'h1;
    localparam logic OFF_ON = 1'h0;

    // one output's setting; packed so a frame slot maps onto it directly
    typedef struct packed {
        logic off;
        logic [SEL_W-1:0] sel;
    } route_type;

    typedef route_type [N_OUT-1:0] route_bank_type;

    // pins of the serial control bus plus the level pins
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic sdin;
        logic cfg;
        logic mode;
        logic rst;
        logic all_on_input0;
    } pin_type;

    // receive sequencer
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ARM = 4'h2,
        ST_SHIFT = 4'h4,
        ST_CLOSE = 4'h8
    } link_state_type;

endpackage

// ---- rtl/pin_sync.sv ----
`timescale 1ns/1ps

// two-stage synchroniser for a group of asynchronous pins
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    // all sync state in one word: stage 1 low half, stage 2 high half
    typedef struct packed {
        logic [WIDTH-1:0] stage2;
        logic [WIDTH-1:0] stage1;
    } sync_state_type;

    sync_state_type state_q; // registered stages
    sync_state_type state_d; // next stages

    initial begin
        if (WIDTH < 1) begin
            $error("pin_sync: WIDTH must be at least 1");
        end
    end

    // stage 1 feeds only stage 2
    always_comb begin
        state_d.stage1 = i_async;
        state_d.stage2 = state_q.stage1;
    end

    // reset to all zero; pins settle within two edges after release
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign o_sync = state_q.stage2;

endmodule

// ---- rtl/xpt_serial_prog.sv ----
`timescale 1ns/1ps

// Summary of operation
// [R1] active bank drives matrix, not software-visible
// [R2] shadow bank shifts, loaded only serially
// [R3] chip select high ignores clock and data
// [R4] arm on first rise, capture next fall
// [R5] controller lowers select before first rise
// [R6] every data bit sampled on falling edge
// [R7] select high then one rise commits
// [R8] configure pulse copies shadow into active
// [R9] configure and mode ignore chip select
// [R10] no new data: configure changes nothing
// [R11] mode high addressed, low serial frame
// [R12] serial frame is 96 bits, 16 outputs
// [R13] six-bit slots: address lsb first, off
// [R14] low select keeps shifting, old bits out
// [R15] controller moves select only clock low
// [R16] controller holds configure low during shift
// [R17] configure may be tied to select
// [R18] word: out addr, in addr, off bit
// [R19] reset level: input 0, all off
// [R20] broadcast level: all on, input 0
// [R21] data out is far end of shadow
// [R22] addressed configure updates named output only
module xpt_serial_prog
    import xpt_pkg::*;
#(
    parameter int OUTPUTS = xpt_pkg::N_OUT,
    parameter int FRAME = xpt_pkg::FRAME_BITS
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_sdin,
    input wire logic i_cfg,
    input wire logic i_mode,
    input wire logic i_rst_pin,
    input wire logic i_all_on_input0,
    output logic o_sdout,
    output xpt_pkg::route_bank_type o_route,
    output logic o_pending
);
    import xpt_pkg::*;

    // logic serves exactly the documented matrix and frame
    initial begin
        if (OUTPUTS != N_OUT || FRAME != OUTPUTS * SLOT_W) begin
            $error("xpt_serial_prog: unsupported OUTPUTS/FRAME");
        end
        if (FRAME < WORD_BITS) begin
            $error("xpt_serial_prog: frame shorter than a word");
        end
    end

    // whole state of the block
    typedef struct packed {
        link_state_type fsm;       // receive sequencer
        logic sclk_prev;           // last synced serial clock
        logic cfg_prev;            // last synced configure
        logic got_bits;            // bits taken in this transfer
        logic pending;             // committed data not yet applied
        logic [FRAME-1:0] shadow;  // shadow shift bank
        route_bank_type active;    // active bank to the matrix
        logic sdout;               // data out flop
    } core_state_type;

    core_state_type state_q; // registered state
    core_state_type state_d; // next state

    pin_type pins_raw;  // pins as they arrive
    pin_type pins;      // pins after two flops

    // all pins are asynchronous to the system clock
    always_comb begin
        pins_raw.cs_n = i_cs_n;
        pins_raw.sclk = i_sclk;
        pins_raw.sdin = i_sdin;
        pins_raw.cfg = i_cfg;
        pins_raw.mode = i_mode;
        pins_raw.rst = i_rst_pin;
        pins_raw.all_on_input0 = i_all_on_input0;
    end

    // one synchroniser for the whole pin group
    pin_sync #(
        .WIDTH($bits(pin_type))
    ) u_pin_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_async(pins_raw),
        .o_sync(pins)
    );

    logic sclk_rise;  // rising serial clock seen this cycle
    logic sclk_fall;  // falling serial clock seen this cycle
    logic cfg_rise;   // configure pulse start
    logic [WORD_BITS-1:0] word;       // last addressed word received
    logic [OADDR_W-1:0] word_oaddr;   // output named in that word
    route_type word_route;            // setting carried by that word

    // edges judged on synced levels only, never on stage 1
    always_comb begin
        sclk_rise = pins.sclk && !state_q.sclk_prev;
        sclk_fall = !pins.sclk && state_q.sclk_prev;
        cfg_rise = pins.cfg && !state_q.cfg_prev;
    end

    // last word sits at the far-in end: bit 0 is the oldest of ten
    always_comb begin
        word = state_q.shadow[FRAME-1 -: WORD_BITS];
        word_oaddr = word[WORD_OADDR_LSB +: OADDR_W];
        // [R18] addressed word fields
        word_route.sel = word[WORD_SEL_LSB +: SEL_W];
        word_route.off = word[WORD_OFF_BIT];
    end

    // next-state logic for the whole block
    always_comb begin
        state_d = state_q;
        state_d.sclk_prev = pins.sclk;
        state_d.cfg_prev = pins.cfg;

        // receive sequencer
        unique case (state_q.fsm)
            ST_IDLE: begin
                // [R3] select high ignores bus
                if (!pins.cs_n) begin
                    state_d.fsm = ST_ARM;
                    state_d.got_bits = 1'b0;
                end
            end
            ST_ARM: begin
                // [R4] arm on first rise
                if (pins.cs_n) begin
                    state_d.fsm = ST_IDLE;
                end else if (sclk_rise) begin
                    state_d.fsm = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (pins.cs_n) begin
                    // bits stay in shadow until a closing rise
                    state_d.fsm = ST_CLOSE;
                end else if (sclk_fall) begin
                    // [R6] sample on falling edge
                    // [R14] shift old contents out
                    // [R2] shadow loads serially only
                    state_d.shadow = {pins.sdin, state_q.shadow[FRAME-1:1]};
                    // [R21] far end to data out
                    state_d.sdout = state_q.shadow[0];
                    state_d.got_bits = 1'b1;
                end
            end
            ST_CLOSE: begin
                // [R7] closing rise commits data
                if (sclk_rise) begin
                    state_d.fsm = ST_IDLE;
                    if (state_q.got_bits) begin
                        state_d.pending = 1'b1;
                    end
                end else if (!pins.cs_n) begin
                    // no closing rise seen: transfer is left uncommitted
                    state_d.fsm = ST_ARM;
                    state_d.got_bits = 1'b0;
                end
            end
            default: begin
                // illegal code: recover to idle
                state_d.fsm = ST_IDLE;
            end
        endcase

        // [R9] configure regardless of select
        // [R10] nothing new, nothing changes
        if (cfg_rise && state_q.pending) begin
            // a commit in this same cycle keeps pending set
            state_d.pending = (state_q.fsm == ST_CLOSE) && sclk_rise
                && state_q.got_bits;
            // [R11] mode picks the format
            if (pins.mode) begin
                // [R22] only the named output
                state_d.active[word_oaddr] = word_route;
            end else begin
                // [R8] copy shadow into active
                // [R12] whole frame, all outputs
                // [R13] slots map onto route_type
                state_d.active = route_bank_type'(state_q.shadow);
            end
        end

        // level pins override the configuration, reset first
        if (pins.rst) begin
            // [R19] input 0, all off
            for (int i = 0; i < OUTPUTS; i++) begin
                state_d.active[i].sel = SEL_INPUT0;
                state_d.active[i].off = OFF_HIZ;
            end
        end else if (pins.all_on_input0) begin
            // [R20] all on input 0
            for (int i = 0; i < OUTPUTS; i++) begin
                state_d.active[i].sel = SEL_INPUT0;
                state_d.active[i].off = OFF_ON;
            end
        end
    end

    // single state register; matrix comes up with all outputs off
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q.fsm <= ST_IDLE;
            state_q.sclk_prev <= 1'b0;
            state_q.cfg_prev <= 1'b0;
            state_q.got_bits <= 1'b0;
            state_q.pending <= 1'b0;
            state_q.shadow <= '0;
            state_q.sdout <= 1'b0;
            for (int i = 0; i < OUTPUTS; i++) begin
                state_q.active[i].sel <= SEL_INPUT0;
                state_q.active[i].off <= OFF_HIZ;
            end
        end else begin
            state_q <= state_d;
        end
    end

    // [R1] active bank drives matrix
    assign o_route = state_q.active;
    assign o_sdout = state_q.sdout;
    assign o_pending = state_q.pending;

endmodule

// ---- verif/xpt_serial_prog_asserts.sv ----
`timescale 1ns/1ps

// watches the programming block from its ports only
module xpt_serial_prog_checker
    import xpt_pkg::*;
#(
    parameter int OUTPUTS = 16,
    parameter int FRAME = 96
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_sdin,
    input wire logic i_cfg,
    input wire logic i_mode,
    input wire logic i_rst_pin,
    input wire logic i_all_on_input0,
    input wire logic o_sdout,
    input wire xpt_pkg::route_bank_type o_route,
    input wire logic o_pending
);
    // either level pin forcing the routes
    wire lvl = i_rst_pin | i_all_on_input0;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    // quiet spans, long enough to outlast the pin synchroniser
    sequence s_no_cfg;
        (!lvl && !i_cfg) [*5];
    endsequence
    sequence s_no_pend;
        (!lvl && !o_pending) [*5];
    endsequence
    property p_rst_lvl;
        i_rst_pin [*4] |-> o_route == {16{6'h20}};
    endproperty
    a_rst_lvl: assert property (p_rst_lvl)
        else $error("reset level left a route on");
    property p_all_on_input0_lvl;
        (i_all_on_input0 && !i_rst_pin) [*4] |-> o_route == '0;
    endproperty
    a_all_on_input0_lvl: assert property (p_all_on_input0_lvl)
        else $error("broadcast level not applied");
    property p_hold;
        s_no_cfg |=> $stable(o_route);
    endproperty
    a_hold: assert property (p_hold)
        else $error("routes moved without configure");
    property p_idle;
        s_no_pend |=> $stable(o_route);
    endproperty
    a_idle: assert property (p_idle)
        else $error("routes moved with nothing pending");
    property p_cause;
        $changed(o_route) |-> $past(o_pending) || $past(lvl, 2);
    endproperty
    a_cause: assert property (p_cause)
        else $error("routes changed with no cause");
    property p_pend_fall;
        $fell(o_pending) |-> $past(i_cfg, 2);
    endproperty
    a_pend_fall: assert property (p_pend_fall)
        else $error("pending cleared without configure");
    // commit after select high and a rise
    property p_pend_rise;
        $rose(o_pending) |-> $past(i_sclk, 2) && $past(i_cs_n, 2);
    endproperty
    a_pend_rise: assert property (p_pend_rise)
        else $error("commit without closing rise");
    // shifts only on a selected fall
    property p_shift;
        $changed(o_sdout) |-> !$past(i_cs_n, 2) && !$past(i_sclk, 2);
    endproperty
    a_shift: assert property (p_shift)
        else $error("data out moved outside a selected fall");
endmodule

bind xpt_serial_prog xpt_serial_prog_checker #(
    .OUTPUTS(OUTPUTS),
    .FRAME(FRAME)
) u_chk (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_cs_n(i_cs_n),
    .i_sclk(i_sclk), .i_sdin(i_sdin), .i_cfg(i_cfg), .i_mode(i_mode),
    .i_rst_pin(i_rst_pin), .i_all_on_input0(i_all_on_input0),
    .o_sdout(o_sdout), .o_route(o_route), .o_pending(o_pending)
);

// ---- verif/serial_ctrl.sv ----
`timescale 1ns/1ps

// controller on the serial bus; four system clocks a clock phase
module serial_ctrl (
    input wire logic i_sys_clk,
    input wire logic i_sdout,
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_sdin
);
    logic [95:0] cap; // bits seen leaving the far end
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_sdin = 1'b0;
        cap = '0;
    end
    // wait whole system clocks
    task automatic half();
        repeat (4) @(posedge i_sys_clk);
    endtask
    // one transfer, bit 0 first; quiet keeps select high
    task automatic send(input logic [95:0] v, input int n, input logic q);
        o_cs_n <= q;
        half();
        for (int i = 0; i < n; i++) begin
            if (i > 0) begin
                cap[i-1] = i_sdout;
            end
            o_sdin <= v[i];
            o_sclk <= 1'b1;
            half();
            o_sclk <= 1'b0;
            half();
        end
        // select high, then one more rise
        o_cs_n <= 1'b1;
        half();
        o_sclk <= 1'b1;
        cap[n-1] = i_sdout;
        o_sdin <= ~o_sdin;
        half();
        o_sclk <= 1'b0;
        half();
    endtask
endmodule

// ---- verif/tb.sv ----
`timescale 1ns/1ps

module tb;
    import xpt_pkg::*;
    localparam logic [95:0] FR_A = 96'h1234_5678_9abc_def0_1357_9bdf;
    logic i_sys_clk, i_rst_n, i_cfg, i_mode, i_rst_pin, i_all_on_input0;
    logic cs_n, sclk, sdin, o_sdout, o_pending;
    logic tie; // three-wire hookup: configure follows select
    wire cfg_pin = tie ? cs_n : i_cfg;
    route_bank_type o_route, want;
    int miscompares, num_checks;
    xpt_serial_prog dut (
        .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_cs_n(cs_n),
        .i_sclk(sclk), .i_sdin(sdin), .i_cfg(cfg_pin), .i_mode(i_mode),
        .i_rst_pin(i_rst_pin), .i_all_on_input0(i_all_on_input0),
        .o_sdout(o_sdout), .o_route(o_route), .o_pending(o_pending)
    );
    serial_ctrl u_ctl (
        .i_sys_clk(i_sys_clk), .i_sdout(o_sdout),
        .o_cs_n(cs_n), .o_sclk(sclk), .o_sdin(sdin)
    );
    initial begin
        i_sys_clk = 1'b0;
        forever #20 i_sys_clk = ~i_sys_clk;
    end
    // one comparison
    task automatic check(input logic [95:0] got, input logic [95:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // configure pulse, held four clocks
    task automatic configure(input logic m);
        i_mode <= m;
        @(posedge i_sys_clk);
        i_cfg <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
        i_cfg <= 1'b0;
        repeat (6) @(posedge i_sys_clk);
    endtask
    task automatic final_report();
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // watchdog, well past the three frames
    initial begin
        repeat (10000) @(posedge i_sys_clk);
        miscompares++;
        $display("[FAIL] t=%0t watchdog expired", $time);
        final_report();
    end
    initial begin
        i_rst_n = 1'b0;
        i_cfg = 1'b0;
        tie = 1'b0;
        i_mode = 1'b0;
        i_rst_pin = 1'b0;
        i_all_on_input0 = 1'b0;
        miscompares = 0;
        num_checks = 0;
        repeat (2) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
        check(o_route, {16{6'h20}});
        u_ctl.send(FR_A, 96, 1'b0);
        check(o_route, {16{6'h20}});
        check({95'h0, o_pending}, 96'h1);
        configure(1'b0);
        check(o_route, FR_A);
        configure(1'b0);
        check(o_route, FR_A);
        $display("test serial frame done");
        u_ctl.send(~FR_A, 96, 1'b1);
        check({95'h0, o_pending}, 96'h0);
        u_ctl.send(~FR_A, 96, 1'b0);
        check(u_ctl.cap, FR_A);
        configure(1'b0);
        check(o_route, ~FR_A);
        $display("test shift through done");
        want = ~FR_A;
        want[5] = {1'b0, 5'h1b};
        u_ctl.send({86'h0, 10'h1b5}, 10, 1'b0);
        configure(1'b1);
        check(o_route, want);
        $display("test addressed done");
        // three-wire: select rise applies the word just shifted in, only while an earlier commit is pending
        tie <= 1'b1;
        repeat (6) @(posedge i_sys_clk);
        u_ctl.send({86'h0, 10'h036}, 10, 1'b0);
        check(o_route, want);
        check({95'h0, o_pending}, 96'h1);
        u_ctl.send({86'h0, 10'h3f7}, 10, 1'b0);
        want[7] = {1'b1, 5'h1f};
        check(o_route, want);
        check({95'h0, o_pending}, 96'h1);
        tie <= 1'b0;
        repeat (6) @(posedge i_sys_clk);
        $display("test three wire done");
        i_rst_pin <= 1'b1;
        repeat (6) @(posedge i_sys_clk);
        check(o_route, {16{6'h20}});
        i_rst_pin <= 1'b0;
        i_all_on_input0 <= 1'b1;
        repeat (6) @(posedge i_sys_clk);
        check(o_route, 96'h0);
        i_all_on_input0 <= 1'b0;
        $display("test level pins done");
        final_report();
    end
endmodule
